// ==== hdl/bct_regs.vh ====
// Constants for the bus-cycle trace capture block: register offsets, field layout, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef BCT_REGS_VH
`define BCT_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word indices on the plain register port)
// ----------------------------------------------------------------
`define BCT_REG_CTRL        4'h0
`define BCT_REG_STATUS      4'h1
`define BCT_REG_DELAY       4'h2
`define BCT_REG_STOP_ADDR   4'h3
`define BCT_REG_READ_SEL    4'h4
`define BCT_REG_REC_ADDR    4'h5
`define BCT_REG_REC_DATA    4'h6
`define BCT_REG_REC_INFO    4'h7
`define BCT_REG_REC_STAMP   4'h8
`define BCT_REG_TRIG_ADDR0  4'h9
`define BCT_REG_TRIG_CTRL   4'hd
`define BCT_REG_COUNT       4'he

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BCT_CTRL_COND_EN    0
`define BCT_CTRL_STOP_EN    1
`define BCT_CTRL_DELAY_EN   2
`define BCT_CTRL_STAMP_LO   4
`define BCT_CTRL_STAMP_HI   7
`define BCT_CTRL_STOP_ON    8
`define BCT_CTRL_DEL_ALL    9
`define BCT_CTRL_RESET      32'h0000_0000

// ----------------------------------------------------------------
// Record layout and limits
// ----------------------------------------------------------------
`define BCT_DEPTH           32768
`define BCT_PTR_W           15
`define BCT_ADDR_W          24
`define BCT_DATA_W          16
`define BCT_CLK_MAX         4'h8
`define BCT_STAMP_W         32

// Area codes
`define BCT_AREA_ROM        3'h0
`define BCT_AREA_RAM        3'h1
`define BCT_AREA_IO8        3'h2
`define BCT_AREA_IO16       3'h3
`define BCT_AREA_EXT8       3'h4
`define BCT_AREA_EXT16      3'h5
`define BCT_AREA_XFER_RAM   3'h6

// Bus status codes
`define BCT_STAT_XFER       3'h0
`define BCT_STAT_PREFETCH   3'h1
`define BCT_STAT_DATA       3'h2
`define BCT_STAT_REFRESH    3'h3
`define BCT_STAT_DMA        3'h4

// ----------------------------------------------------------------
// Time stamp resolutions, in ns, and the clock period
// ----------------------------------------------------------------
`define BCT_CLK_PERIOD_NS   5
`define BCT_RES0_NS         125
`define BCT_RES1_NS         250
`define BCT_RES2_NS         500
`define BCT_RES3_NS         1000
`define BCT_RES4_NS         2000
`define BCT_RES5_NS         4000
`define BCT_RES6_NS         8000
`define BCT_RES7_NS         16000
`define BCT_RES8_NS         100000

`endif

// ==== hdl/bct_stamp.v ====
// Time stamp counter for the bus-cycle trace capture block.
// Assumes clk_in at 200 MHz; start_in is already synchronous to clk_in.
`timescale 1ns/1ps
`include "bct_regs.vh"

module bct_stamp #(
    parameter STAMP_W = `BCT_STAMP_W
) (
    input  wire               clk_in,
    input  wire               reset_n_in,
    input  wire               ce_in,
    input  wire               start_in,
    input  wire [3:0]         res_sel_in,
    output reg  [STAMP_W-1:0] stamp_out
);

    // ----------------------------------------------------------------
    // Prescaler: cycles per stamp tick, rounded down from the resolution
    // ----------------------------------------------------------------
    function [31:0] bct_ticks;
        input [3:0] sel;
        begin
            case (sel)
                4'h1:    bct_ticks = `BCT_RES0_NS / `BCT_CLK_PERIOD_NS;
                4'h2:    bct_ticks = `BCT_RES1_NS / `BCT_CLK_PERIOD_NS;
                4'h3:    bct_ticks = `BCT_RES2_NS / `BCT_CLK_PERIOD_NS;
                4'h4:    bct_ticks = `BCT_RES3_NS / `BCT_CLK_PERIOD_NS;
                4'h5:    bct_ticks = `BCT_RES4_NS / `BCT_CLK_PERIOD_NS;
                4'h6:    bct_ticks = `BCT_RES5_NS / `BCT_CLK_PERIOD_NS;
                4'h7:    bct_ticks = `BCT_RES6_NS / `BCT_CLK_PERIOD_NS;
                4'h8:    bct_ticks = `BCT_RES7_NS / `BCT_CLK_PERIOD_NS;
                4'h9:    bct_ticks = `BCT_RES8_NS / `BCT_CLK_PERIOD_NS;
                default: bct_ticks = 32'h0000_0000;
            endcase
        end
    endfunction

    reg  [15:0] prescale;
    wire [31:0] ticks = bct_ticks(res_sel_in);
    // Largest resolution still fits in sixteen bits of prescale
    wire [15:0] limit = ticks[15:0];

    // Clear at program start, then count; wraps to zero on overflow
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            prescale  <= 16'h0000;
            stamp_out <= {STAMP_W{1'b0}};
        end else if (ce_in) begin
            if (start_in) begin
                prescale  <= 16'h0000;
                stamp_out <= {STAMP_W{1'b0}};
            end else if (limit != 16'h0000) begin
                if (prescale == limit - 16'h0001) begin
                    prescale  <= 16'h0000;
                    stamp_out <= stamp_out + 1'b1;
                end else begin
                    prescale <= prescale + 16'h0001;
                end
            end
        end
    end

endmodule

// ==== hdl/bct_capture.v ====
// Bus-cycle trace capture: one record per target bus cycle into a circular buffer.
// Assumes target bus pins are asynchronous and pass two flip-flops; host port is synchronous.
`timescale 1ns/1ps
`include "bct_regs.vh"

module bct_capture #(
    parameter DEPTH = `BCT_DEPTH,
    parameter PTR_W = `BCT_PTR_W
) (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire        ce_in,
    input  wire        run_in,
    input  wire        bus_cycle_in,
    input  wire [23:0] bus_addr_in,
    input  wire [15:0] bus_data_in,
    input  wire        bus_wide_in,
    input  wire        bus_write_in,
    input  wire [2:0]  bus_area_in,
    input  wire [2:0]  bus_status_in,
    input  wire [3:0]  probe_in,
    input  wire        nmi_in,
    input  wire [7:0]  interrupt_request_inputs_in,
    input  wire [3:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_write_in,
    input  wire        reg_read_in,
    output reg  [31:0] reg_rdata_out,
    output reg  [3:0]  trigger_out,
    output reg         capturing_out
);

    // ----------------------------------------------------------------
    // Input synchronisers: two flops before any logic
    // ----------------------------------------------------------------
    localparam SW = 1 + 1 + 24 + 16 + 1 + 1 + 3 + 3 + 4 + 1 + 8;
    wire [SW-1:0] raw = {run_in, bus_cycle_in, bus_addr_in, bus_data_in, bus_wide_in,
                         bus_write_in, bus_area_in, bus_status_in, probe_in, nmi_in,
                         interrupt_request_inputs_in};
    reg  [SW-1:0] sync_a;
    reg  [SW-1:0] sync_b;

    // Bus fields are quasi-static across a cycle, so bitwise sync is acceptable
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_a <= {SW{1'b0}};
            sync_b <= {SW{1'b0}};
        end else if (ce_in) begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    wire        s_run    = sync_b[SW-1];
    wire        s_cyc    = sync_b[SW-2];
    wire [23:0] s_addr   = sync_b[SW-3 -: 24];
    wire [15:0] s_data   = sync_b[SW-27 -: 16];
    wire        s_wide   = sync_b[20];
    wire        s_write  = sync_b[19];
    wire [2:0]  s_area   = sync_b[18:16];
    wire [2:0]  s_status = sync_b[15:13];
    wire [3:0]  s_probe  = sync_b[12:9];
    wire        s_nmi    = sync_b[8];
    wire [7:0]  s_irq    = sync_b[7:0];

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    reg  [31:0]      ctrl;
    reg  [PTR_W-1:0] delay_cnt;
    reg  [23:0]      stop_addr;
    reg  [PTR_W-1:0] read_sel;
    reg  [23:0]      trig_addr [0:3];
    reg  [3:0]       trig_en;
    reg              run_d;
    reg              stopped;
    reg              stop_hit;
    reg  [PTR_W-1:0] delay_left;
    reg  [PTR_W-1:0] wr_ptr;
    reg  [PTR_W-1:0] stop_ptr;
    reg  [PTR_W:0]   count;
    reg  [3:0]       clk_cnt;
    reg              prev_cyc;

    wire [3:0]  stamp_sel = ctrl[`BCT_CTRL_STAMP_HI:`BCT_CTRL_STAMP_LO];
    wire        stamp_on  = (stamp_sel != 4'h0);
    wire        start     = s_run & ~run_d;
    wire [31:0] stamp;

    bct_stamp #(
        .STAMP_W (`BCT_STAMP_W)
    ) u_stamp (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .start_in   (start),
        .res_sel_in (stamp_sel),
        .stamp_out  (stamp)
    );

    // ----------------------------------------------------------------
    // Record storage: flip-flop arrays indexed by write pointer
    // ----------------------------------------------------------------
    reg [23:0] mem_addr  [0:DEPTH-1];
    reg [15:0] mem_data  [0:DEPTH-1];
    reg [31:0] mem_info  [0:DEPTH-1];
    reg [31:0] mem_stamp [0:DEPTH-1];

    // Cycle ends on falling edge of the synchronised cycle strobe
    wire cyc_end = prev_cyc & ~s_cyc;
    // No filtering: every cycle from start to halt, until stop/delay completes
    // Gating on the synced run level keeps a cycle ending at halt off the oldest slot
    wire take = cyc_end & capturing_out & s_run & ~stopped;
    // Stop point match; a disabled stop point never fires
    wire stop_match = ctrl[`BCT_CTRL_STOP_EN] & (s_addr == stop_addr) & ~stop_hit;

    // Bus clock length, saturating one above the maximum
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_cnt  <= 4'h0;
            prev_cyc <= 1'b0;
        end else if (ce_in) begin
            prev_cyc <= s_cyc;
            if (cyc_end | ~s_cyc)
                clk_cnt <= 4'h0;
            else if (clk_cnt <= `BCT_CLK_MAX)
                clk_cnt <= clk_cnt + 4'h1;
        end
    end

    // Info word: stamp replaces area/status/clock/probes/interrupts
    wire        sat      = (clk_cnt > `BCT_CLK_MAX);       // count_saturated_marker
    wire [31:0] info_raw = {6'h00, sat, clk_cnt, s_area, s_status, s_probe, s_nmi, s_irq, 2'b00};
    wire [31:0] info     = stamp_on ? stamp : info_raw;
    wire [15:0] data_cap = s_wide ? s_data : {8'h00, s_data[7:0]};

    // Record write: one per completed cycle, wrapping pointer
    always @(posedge clk_in) begin
        if (ce_in & take) begin
            mem_addr[wr_ptr] <= s_addr;
            mem_data[wr_ptr] <= data_cap;
            mem_info[wr_ptr] <= {info[31:1], s_write};
            mem_stamp[wr_ptr] <= stamp_on ? stamp : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Run tracking, pointer, stop and delay sequencing
    // ----------------------------------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_d         <= 1'b0;
            capturing_out <= 1'b0;
            stopped       <= 1'b0;
            stop_hit      <= 1'b0;
            delay_left    <= {PTR_W{1'b0}};
            wr_ptr        <= {PTR_W{1'b0}};
            stop_ptr      <= {PTR_W{1'b0}};
            count         <= {(PTR_W+1){1'b0}};
        end else if (ce_in) begin
            run_d <= s_run;
            if (start) begin
                capturing_out <= 1'b1;
                stopped       <= 1'b0;
                stop_hit      <= 1'b0;
                wr_ptr        <= {PTR_W{1'b0}};
                count         <= {(PTR_W+1){1'b0}};
            end else if (!s_run) begin
                capturing_out <= 1'b0;
            end else if (take) begin
                wr_ptr <= wr_ptr + 1'b1;
                if (count != DEPTH)
                    count <= count + 1'b1;
                if (stop_match) begin
                    stop_hit <= 1'b1;
                    stop_ptr <= wr_ptr;
                    delay_left <= delay_cnt;
                    if (!ctrl[`BCT_CTRL_DELAY_EN] || delay_cnt == {PTR_W{1'b0}})
                        stopped <= 1'b1;
                end else if (stop_hit && !stopped) begin
                    if (delay_left <= {{(PTR_W-1){1'b0}}, 1'b1})
                        stopped <= 1'b1;
                    delay_left <= delay_left - 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Trigger outputs: address match while the channel is enabled
    // ----------------------------------------------------------------
    integer t;
    reg [3:0] next_trigger;
    always @* begin
        next_trigger = 4'h0;
        for (t = 0; t < 4; t = t + 1)
            next_trigger[t] = trig_en[t] & s_cyc & s_run & (s_addr == trig_addr[t]);
    end

    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            trigger_out <= 4'h0;
        else if (ce_in)
            trigger_out <= next_trigger;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    integer k;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl      <= `BCT_CTRL_RESET;
            delay_cnt <= {PTR_W{1'b0}};
            stop_addr <= 24'h00_0000;
            read_sel  <= {PTR_W{1'b0}};
            trig_en   <= 4'h0;
            for (k = 0; k < 4; k = k + 1)
                trig_addr[k] <= 24'h00_0000;
        end else if (ce_in && reg_write_in) begin
            if (reg_addr_in == `BCT_REG_CTRL) begin
                ctrl <= {22'h0, 1'b0, reg_wdata_in[8:0]};
                // Delete-all keeps trigger addresses and only disables channels
                if (reg_wdata_in[`BCT_CTRL_DEL_ALL])
                    trig_en <= 4'h0;
            end else if (reg_addr_in == `BCT_REG_DELAY)
                delay_cnt <= reg_wdata_in[PTR_W-1:0];
            else if (reg_addr_in == `BCT_REG_STOP_ADDR)
                stop_addr <= reg_wdata_in[23:0];
            else if (reg_addr_in == `BCT_REG_READ_SEL)
                read_sel <= reg_wdata_in[PTR_W-1:0];
            else if (reg_addr_in >= `BCT_REG_TRIG_ADDR0 && reg_addr_in < `BCT_REG_TRIG_CTRL)
                trig_addr[reg_addr_in[1:0] - 2'h1] <= reg_wdata_in[23:0];
            else if (reg_addr_in == `BCT_REG_TRIG_CTRL)
                trig_en <= reg_wdata_in[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Register reads: record_index is signed, relative to newest/stop
    // ----------------------------------------------------------------
    // Base is newest record, or the stop record once the stop point has matched
    wire [PTR_W-1:0] base    = stop_hit ? stop_ptr : wr_ptr - 1'b1;
    wire [PTR_W-1:0] rd_slot = base + read_sel;            // record_index, two's complement
    reg  [31:0]      next_rdata;

    always @* begin
        if (reg_addr_in == `BCT_REG_CTRL)
            next_rdata = ctrl;
        else if (reg_addr_in == `BCT_REG_STATUS)
            next_rdata = {28'h0, stop_hit, stopped, stamp_on, capturing_out};
        else if (reg_addr_in == `BCT_REG_DELAY)
            next_rdata = {17'h0, delay_cnt};
        else if (reg_addr_in == `BCT_REG_STOP_ADDR)
            next_rdata = {8'h00, stop_addr};
        else if (reg_addr_in == `BCT_REG_READ_SEL)
            next_rdata = {17'h0, read_sel};
        else if (reg_addr_in == `BCT_REG_REC_ADDR)
            next_rdata = {8'h00, mem_addr[rd_slot]};
        else if (reg_addr_in == `BCT_REG_REC_DATA)
            next_rdata = {16'h0000, mem_data[rd_slot]};
        else if (reg_addr_in == `BCT_REG_REC_INFO)
            next_rdata = mem_info[rd_slot];
        else if (reg_addr_in == `BCT_REG_REC_STAMP)
            next_rdata = mem_stamp[rd_slot];
        else if (reg_addr_in == `BCT_REG_TRIG_CTRL)
            next_rdata = {28'h0, trig_en};
        else if (reg_addr_in == `BCT_REG_COUNT)
            next_rdata = {16'h0000, count};
        else if (reg_addr_in >= `BCT_REG_TRIG_ADDR0 && reg_addr_in < `BCT_REG_TRIG_CTRL)
            next_rdata = {8'h00, trig_addr[reg_addr_in[1:0] - 2'h1]};
        else
            next_rdata = stamp;
    end

    // Read data stand for exactly the cycle after the strobe
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (ce_in)
            reg_rdata_out <= reg_read_in ? next_rdata : 32'h0000_0000;
    end

endmodule

// ==== verif/bct_capture_checker.sv ====
// Checker for the trace capture block: run, trigger and register read timing.
// Assumes one clock domain; bound to every bct_capture instance.
`timescale 1ns/1ps
module bct_capture_checker (
    input wire logic        clk_in,
    input wire logic        reset_n_in,
    input wire logic        run_in,
    input wire logic        bus_cycle_in,
    input wire logic [3:0]  reg_addr_in,
    input wire logic        reg_read_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [3:0]  trigger_out,
    input wire logic        capturing_out
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Outputs leave reset quiet
    a_reset_quiet: assert property (
        $rose(reset_n_in) |-> !capturing_out && trigger_out == 4'h0 && reg_rdata_out == 32'h0)
        else $error("outputs not quiet after reset");
    // Read data stand only in the cycle after a read strobe
    a_rdata_one_cycle: assert property (
        !$past(reg_read_in) |-> reg_rdata_out == 32'h0)
        else $error("read data without a read strobe");
    // Sync delay of the run input bounds both capture edges
    a_run_starts_capture: assert property (
        $rose(run_in) |-> ##[1:5] capturing_out)
        else $error("capture did not start after program start");
    a_halt_ends_capture: assert property (
        $fell(run_in) |-> ##[1:5] !capturing_out)
        else $error("capture did not end after program halt");
    a_no_run_no_capture: assert property (
        (!run_in) [*5] |-> !capturing_out)
        else $error("capturing while program halted");
    a_capture_cause: assert property (
        $rose(capturing_out) |-> run_in && $past(run_in))
        else $error("capture started without a program run");
    // A trigger needs a bus cycle behind it
    a_trig_needs_cycle: assert property (
        (!bus_cycle_in) [*6] |-> trigger_out == 4'h0)
        else $error("trigger without a bus cycle");
    // Status bit 0 mirrors the capture flag while it is steady
    a_status_mirror: assert property (
        reg_read_in && reg_addr_in == 4'h1 && $stable(capturing_out) ##1 $stable(capturing_out)
        |-> reg_rdata_out[0] == capturing_out)
        else $error("status capture bit differs from capture flag");
    c_capture: cover property ($rose(capturing_out));
    c_trigger: cover property (trigger_out != 4'h0);
    c_info_read: cover property (reg_read_in && reg_addr_in == 4'h7);
endmodule

bind bct_capture bct_capture_checker chk (.clk_in, .reset_n_in, .run_in, .bus_cycle_in,
    .reg_addr_in, .reg_read_in, .reg_rdata_out, .trigger_out, .capturing_out);

// ==== verif/bct_bus_model.sv ====
// Target bus model: one bus cycle per call, fields packed into one vector.
// Assumes the caller shares the clock and waits for each call to return.
`timescale 1ns/1ps
module bct_bus_model (
    input  wire logic        clk_in,
    output logic             bus_cycle_out,
    output logic [60:0]      fields_out
);
    // ------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------
    initial begin
        bus_cycle_out = 1'b0;
        fields_out = 61'h0;
    end
    // Fields are held past the cycle end to cover the sync delay, then
    // inverted so a late sample cannot pass on stale values
    task automatic do_cycle(input logic [60:0] f, input int n);
        @(posedge clk_in);
        fields_out <= f;
        bus_cycle_out <= 1'b1;
        repeat (n) @(posedge clk_in);
        bus_cycle_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        fields_out <= ~f;
    endtask
endmodule

// ==== verif/tb.sv ====
// Testbench for the trace capture block with a small buffer.
// Assumes the bus model in bct_bus_model and constants from bct_regs.vh.
`timescale 1ns/1ps
`include "bct_regs.vh"
module tb;
    typedef struct packed {
        logic [60:0] f;
        logic [3:0]  n;
        logic [31:0] info;
    } row_t;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        ce_in = 1'b1;
    logic        run_in = 1'b0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0;
    logic        reg_write_in = 1'b0;
    logic        reg_read_in = 1'b0;
    logic [3:0]  trig_seen = 4'h0;
    logic        trig_clr = 1'b0;
    wire  [31:0] reg_rdata_out;
    wire  [3:0]  trigger_out;
    wire         capturing_out, bus_cycle_in, bus_wide_in, bus_write_in, nmi_in;
    wire  [60:0] flds;
    wire  [23:0] bus_addr_in;
    wire  [15:0] bus_data_in;
    wire  [2:0]  bus_area_in, bus_status_in;
    wire  [3:0]  probe_in;
    wire  [7:0]  interrupt_request_inputs_in;
    int          bad_count = 0;
    int          checks_done = 0;
    row_t        rows [8];

    // ------------------------------------------------------------
    // Clock, wiring, instances
    // ------------------------------------------------------------
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) trig_seen <= trig_clr ? 4'h0 : (trig_seen | trigger_out);
    assign {bus_addr_in, bus_data_in, bus_wide_in, bus_write_in, bus_area_in, bus_status_in,
            probe_in, nmi_in, interrupt_request_inputs_in} = flds;
    bct_bus_model bus (.clk_in, .bus_cycle_out(bus_cycle_in), .fields_out(flds));
    // Small buffer keeps the wrap test short
    bct_capture #(.DEPTH(16), .PTR_W(4)) dut (.clk_in, .reset_n_in, .ce_in, .run_in,
        .bus_cycle_in, .bus_addr_in, .bus_data_in, .bus_wide_in, .bus_write_in, .bus_area_in,
        .bus_status_in, .probe_in, .nmi_in, .interrupt_request_inputs_in, .reg_addr_in,
        .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .trigger_out,
        .capturing_out);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_wdata_in <= v;
        reg_write_in <= 1'b1;
        @(posedge clk_in);
        reg_write_in <= 1'b0;
    endtask
    // Read data are taken mid-cycle, in the one cycle they stand
    task automatic rd(input logic [3:0] ad, output logic [31:0] v);
        @(posedge clk_in);
        reg_addr_in <= ad;
        reg_read_in <= 1'b1;
        @(posedge clk_in);
        reg_read_in <= 1'b0;
        @(negedge clk_in);
        v = reg_rdata_out;
    endtask
    task automatic rec(input int idx, output logic [31:0] a, d, inf, s);
        wr(`BCT_REG_READ_SEL, 32'(idx));
        rd(`BCT_REG_REC_ADDR, a);
        rd(`BCT_REG_REC_DATA, d);
        rd(`BCT_REG_REC_INFO, inf);
        rd(`BCT_REG_REC_STAMP, s);
    endtask
    task automatic go(input logic on);
        int k;
        @(posedge clk_in);
        run_in <= on;
        k = 0;
        while (capturing_out !== on && k < 20) begin
            @(posedge clk_in);
            k++;
        end
        chk("capturing", {31'h0, on}, {31'h0, capturing_out});
    endtask
    task automatic trig(input logic [3:0] e);
        trig_clr <= 1'b1;
        @(posedge clk_in);
        trig_clr <= 1'b0;
        bus.do_cycle({24'h000500, 37'h0}, 2);
        repeat (4) @(posedge clk_in);
        chk("trigger", {28'h0, e}, {28'h0, trig_seen});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog, sized well above the few hundred cycles needed
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        $display("watchdog expired");
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        row_t r;
        logic [31:0] a, d, inf, s, s0, m;
        // Rows cover every area and status code, both widths and directions
        for (int i = 0; i < 8; i++) begin
            r.f = {24'(32'h5a1000 + i * 32'h0203), 16'(32'h8421 + i * 32'h1357), i[0], i[1],
                   3'(i % 7), 3'(i % 5), 4'(3 * i + 1), i[2], 8'(1 << i)};
            r.n = 4'(i + 1 + i / 6);
            r.info = {6'h0, r.n > 4'h8, r.n > 4'h8 ? 4'h0 : r.n, r.f[18:16], r.f[15:13],
                      r.f[12:9], r.f[8], r.f[7:0], 1'b0, r.f[19]};
            rows[i] = r;
        end
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd(`BCT_REG_CTRL, a);
        chk("ctrl reset", `BCT_CTRL_RESET, a);
        rd(`BCT_REG_STATUS, a);
        chk("status reset", 32'h0, a);
        $display("test reset done");
        // Free mode, no stamp: one record per cycle, read back oldest first
        go(1'b1);
        for (int i = 0; i < 8; i++) bus.do_cycle(rows[i].f, rows[i].n);
        go(1'b0);
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            rec(i - 7, a, d, inf, s);
            chk("rec addr", {8'h0, r.f[60:37]}, a);
            m = r.f[20] ? 32'h0000ffff : 32'h000000ff;
            chk("rec data", {16'h0, r.f[36:21]} & m, d & m);
            m = r.n > 4'h8 ? 32'h01e00000 : 32'h0;
            chk("rec info", r.info | m, inf | m);
            chk("rec stamp off", 32'h0, s);
        end
        $display("test rows done");
        // Stamped run longer than the buffer: oldest records overwritten
        wr(`BCT_REG_CTRL, 32'h00000010);
        go(1'b1);
        for (int i = 0; i < 20; i++) bus.do_cycle({24'(i), 16'h0, 2'b01, 19'h0}, 1);
        go(1'b0);
        rec(0, a, d, inf, s0);
        chk("newest addr", 32'd19, a);
        chk("stamp in info", {s0[31:1], 1'b1}, inf);
        rec(-15, a, d, inf, s);
        chk("oldest addr", 32'd4, a);
        rd(`BCT_REG_COUNT, a);
        chk("record count", 32'd16, a);
        chk("stamp order", 32'h1, {31'h0, s0 >= 32'd3 && s <= s0});
        $display("test wrap done");
        // Stop at an address with a delay of two cycles
        wr(`BCT_REG_DELAY, 32'h2);
        wr(`BCT_REG_STOP_ADDR, 32'h000300);
        wr(`BCT_REG_CTRL, 32'h00000016);
        go(1'b1);
        for (int i = 0; i < 6; i++) bus.do_cycle({24'(32'h2ff + i), 37'h0}, 1);
        go(1'b0);
        for (int i = -1; i < 3; i++) begin
            rec(i, a, d, inf, s);
            chk("delay addr", 32'(32'h300 + i), a);
            if (i < 0) chk("first stamp", 32'h0, s);
        end
        rd(`BCT_REG_STATUS, a);
        chk("stop hit", 32'h8, a & 32'h8);
        $display("test delay done");
        // Trigger channel enabled, disabled, then delete-all
        wr(`BCT_REG_CTRL, 32'h0);
        wr(`BCT_REG_TRIG_ADDR0, 32'h000500);
        wr(`BCT_REG_TRIG_CTRL, 32'h1);
        go(1'b1);
        trig(4'h1);
        wr(`BCT_REG_TRIG_CTRL, 32'h0);
        trig(4'h0);
        wr(`BCT_REG_TRIG_CTRL, 32'h1);
        wr(`BCT_REG_CTRL, 32'h00000200);
        trig(4'h0);
        rd(`BCT_REG_TRIG_ADDR0, a);
        chk("trigger addr kept", 32'h000500, a);
        rd(`BCT_REG_TRIG_CTRL, a);
        chk("trigger disabled", 32'h0, a);
        go(1'b0);
        $display("test trigger done");
        print_verdict();
    end
endmodule
